// ===== bench/emsb_ctrl_props.sv
module emsb_ctrl_props
    import emsb_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic req_ready,
    input wire logic rd_valid,
    input wire logic wr_data_take,
    input wire logic bus_hold_req_n,
    input wire logic grant_suppress,
    input wire logic bus_grant_ack_n,
    input wire logic [3:0] chip_sel_oe_n,
    input wire logic [3:0] byte_lane_select_oe_n,
    input wire logic [31:0] mem_data_bus_oe_n,
    input wire logic [19:0] mem_word_addr_oe_n,
    input wire emsb_strobe_t strobe,
    input wire logic [2:0] strobe_oe_n
);
    logic [7:0] cnt_q, cnt_d;
    logic hold_q;
    logic [1:0] beat_q, beat_d;
    wire logic beat = rd_valid | wr_data_take;
    wire logic flt = &{chip_sel_oe_n, byte_lane_select_oe_n, mem_data_bus_oe_n,
        mem_word_addr_oe_n, strobe_oe_n};
    // Cycles since the takeover request last changed, saturating
    always_comb begin
        cnt_d = (bus_hold_req_n != hold_q) ? 8'h00 : cnt_q + {7'h0, cnt_q != 8'hff};
        beat_d = beat_q + {1'h0, beat};
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_q <= 8'hff;
            hold_q <= 1'h1;
            beat_q <= 2'h0;
        end else begin
            cnt_q <= cnt_d;
            hold_q <= bus_hold_req_n;
            beat_q <= beat_d;
        end
    end
    default clocking @(posedge clk);
    endclocking
    default disable iff (rst);
    sequence s_float;
        $rose(chip_sel_oe_n[0]);
    endsequence
    sequence s_drive;
        $fell(chip_sel_oe_n[0]);
    endsequence
    sequence s_next_beat;
        ##[12:13] beat;
    endsequence
    a_row_on_take: assert property (req_ready |=> strobe.row_strobe_n != strobe.col_strobe_n)
        else $error("row strobe missing after take");
    a_beats_no_gap: assert property (beat && beat_q != 2'h3 |-> s_next_beat)
        else $error("gap in burst data");
    a_float_not_early: assert property (s_float |-> cnt_q >= 8'h18 && !bus_hold_req_n)
        else $error("bus floated too early");
    a_ack_in_time: assert property (s_float |-> ##[1:26] !bus_grant_ack_n)
        else $error("grant late after float");
    a_drive_window: assert property (s_drive |-> cnt_q >= 8'h18 && cnt_q <= 8'h57)
        else $error("bus redriven outside window");
    a_ack_release: assert property (s_drive |-> ##[1:26] bus_grant_ack_n)
        else $error("grant not released");
    a_no_grant_busy: assert property (beat |-> bus_grant_ack_n && chip_sel_oe_n == 4'h0)
        else $error("grant during burst");
    a_suppress_hold: assert property (grant_suppress && bus_grant_ack_n |=> bus_grant_ack_n)
        else $error("grant while suppressed");
    a_float_all: assert property (!bus_grant_ack_n && !bus_hold_req_n |-> flt)
        else $error("pin driven during grant");
endmodule : emsb_ctrl_props

// ===== bench/emsb_sdram_model.sv
module emsb_sdram_model
    import emsb_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic mem_clk_out,
    input wire emsb_strobe_t strobe,
    input wire logic [19:0] mem_word_addr,
    output logic [31:0] rd_word
);
    logic mco_q;
    logic rd_q, rd_d;
    logic [2:0] left_q, left_d;
    logic [19:0] col_q, col_d;
    logic [31:0] word_d;
    always_comb begin
        rd_d = rd_q;
        left_d = left_q;
        col_d = col_q;
        if (mem_clk_out && !mco_q) begin
            if (!strobe.col_strobe_n && strobe.row_strobe_n) begin
                rd_d = strobe.sdram_write_strobe_n;
                left_d = 3'h4;
                col_d = mem_word_addr;
            end else if (left_q != 3'h0) begin
                left_d = left_q - 3'h1;
                col_d = col_q + 20'h1;
            end
        end
        // Outside a read the bus toggles so a stale word never passes
        word_d = (rd_q && left_q != 3'h0) ? {12'h5a5, col_q} : ~rd_word;
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mco_q <= 1'h0;
            rd_q <= 1'h0;
            left_q <= 3'h0;
            col_q <= 20'h0;
            rd_word <= 32'h0;
        end else begin
            mco_q <= mem_clk_out;
            rd_q <= rd_d;
            left_q <= left_d;
            col_q <= col_d;
            rd_word <= word_d;
        end
    end
endmodule : emsb_sdram_model

// ===== bench/testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    import emsb_pkg::*;
    typedef struct {logic w; emsb_order_t o; logic [19:0] a; logic [2:0] c; logic [19:0] l;} emsb_row_t;
    logic clk, rst, mem_clk_in, mem_clk_out, req_valid, req_ready, wr_data_take, rd_valid;
    logic bus_hold_req_n, grant_suppress, bus_grant_ack_n, mco_q, wd_q;
    emsb_req_t req;
    emsb_strobe_t strobe;
    logic [31:0] wr_data, rd_data, mem_data_bus_o, mem_data_bus_oe_n, rd_word;
    logic [3:0] wr_be_n, chip_sel_n, chip_sel_oe_n, byte_lane_select_n, byte_lane_select_oe_n;
    logic [19:0] mem_word_addr, mem_word_addr_oe_n, last_col;
    logic [2:0] strobe_oe_n;
    int fails = 0, num_checks = 0, beats, cols;
    emsb_row_t rows[6] = '{'{1'h0, EMSB_ORD_INC, 20'h00100, 3'h1, 20'h00100},
        '{1'h1, EMSB_ORD_INC, 20'hfffff, 3'h1, 20'hfffff},
        '{1'h0, EMSB_ORD_DEC, 20'h00208, 3'h4, 20'h00205},
        '{1'h1, EMSB_ORD_DEC, 20'h00003, 3'h4, 20'h00000},
        '{1'h0, EMSB_ORD_RND, 20'h00310, 3'h4, 20'h0},
        '{1'h1, EMSB_ORD_RND, 20'h00311, 3'h4, 20'h0}};
    emsb_ctrl i_dut (.*, .mem_data_bus_i(rd_word));
    emsb_sdram_model i_mem (.*);
    initial begin
        clk = 0;
        forever #5 clk = ~clk;
    end
    initial begin
        mem_clk_in = 0;
        #3;
        forever #62.5 mem_clk_in = ~mem_clk_in;
    end
    task automatic end_sim;
        if (fails == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : end_sim
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: %s got %h", $time, what, got);
        end
    endtask : cmp
    // Holds the request until the design takes it; a chained caller keeps valid up
    task automatic do_req(input logic w, input emsb_order_t o, input logic [19:0] a,
        input bit last);
        int n;
        n = 0;
        @(posedge clk);
        #1;
        req = '{write: w, order: o, addr: a, cs_n: 4'he};
        wr_data = {12'h0, a};
        req_valid = 1;
        do begin
            @(negedge clk);
            n++;
        end while (req_ready !== 1'b1 && n < 500);
        cmp(n < 500, 1, "request taken");
        @(posedge clk);
        #1 req_valid = !last;
    endtask : do_req
    task automatic wait_ack(input logic v);
        for (int n = 0; n < 400 && bus_grant_ack_n !== v; n++) @(posedge clk);
        #1;
        cmp(bus_grant_ack_n, v, "grant ack");
    endtask : wait_ack
    // Sampled mid-cycle so no output is read in the time step that launches it
    always @(negedge clk) begin
        mco_q <= mem_clk_out;
        wd_q <= (wr_data_take === 1'b1);
        if (rd_valid === 1'b1 || wr_data_take === 1'b1) beats++;
        if (rd_valid === 1'b1) cmp(rd_data[31:20], 12'h5a5, "read word");
        if (wd_q && !rst) cmp(mem_data_bus_o, wr_data, "write data");
        if (wd_q && !rst) cmp(mem_data_bus_oe_n, 32'h0, "write lanes driven");
        if (mem_clk_out && !mco_q && !strobe.col_strobe_n && strobe.row_strobe_n) begin
            cols++;
            last_col = mem_word_addr;
        end
    end
    initial begin
        #200000;
        fails++;
        end_sim();
    end
    initial begin
        rst = 1;
        req_valid = 0;
        req = '0;
        wr_data = 32'h0;
        wr_be_n = 4'h0;
        bus_hold_req_n = 1;
        grant_suppress = 0;
        repeat (10) @(posedge clk);
        #1 cmp({bus_grant_ack_n, strobe, chip_sel_n}, 8'hff, "reset pins");
        rst = 0;
        repeat (20) @(posedge clk);
        foreach (rows[i]) begin
            beats = 0;
            cols = 0;
            do_req(rows[i].w, rows[i].o, rows[i].a, 1'b1);
            repeat (100) @(posedge clk);
            cmp(beats, 4, "beats");
            cmp(cols, rows[i].c, "column commands");
            if (rows[i].o != EMSB_ORD_RND) cmp(last_col, rows[i].l, "last column");
        end
        beats = 0;
        do_req(1'h0, EMSB_ORD_INC, 20'h00400, 1'b0);
        do_req(1'h1, EMSB_ORD_DEC, 20'h00500, 1'b1);
        repeat (100) @(posedge clk);
        cmp(beats, 8, "chained beats");
        beats = 0;
        fork
            do_req(1'h0, EMSB_ORD_INC, 20'h00600, 1'b1);
            begin
                repeat (30) @(posedge clk);
                #1 bus_hold_req_n = 0;
            end
        join
        wait_ack(1'h0);
        cmp(beats, 4, "burst before grant");
        cmp(&{chip_sel_oe_n, byte_lane_select_oe_n, strobe_oe_n, mem_word_addr_oe_n,
            mem_data_bus_oe_n}, 1, "floated");
        repeat (13) @(posedge clk);
        #1 bus_hold_req_n = 1;
        wait_ack(1'h1);
        cmp(chip_sel_oe_n, 4'h0, "bus driven again");
        grant_suppress = 1;
        bus_hold_req_n = 0;
        repeat (300) @(posedge clk);
        #1 cmp(bus_grant_ack_n, 1'h1, "suppressed grant");
        bus_hold_req_n = 1;
        repeat (40) @(posedge clk);
        #1 grant_suppress = 0;
        do_req(1'h1, EMSB_ORD_INC, 20'h00700, 1'b1);
        repeat (20) @(posedge clk);
        #1 rst = 1;
        #20 cmp({bus_grant_ack_n, strobe, chip_sel_n}, 8'hff, "mid-run reset");
        rst = 0;
        beats = 0;
        do_req(1'h0, EMSB_ORD_INC, 20'h00800, 1'b1);
        repeat (100) @(posedge clk);
        cmp(beats, 4, "beats after reset");
        end_sim();
    end
endmodule : testbench
bind emsb_ctrl emsb_ctrl_props i_props (.*);

// ===== rtl/emsb_ctrl.sv
module emsb_ctrl
    import emsb_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic mem_clk_in,
    output logic mem_clk_out,
    input wire logic req_valid,
    output logic req_ready,
    input wire emsb_req_t req,
    input wire logic [31:0] wr_data,
    input wire logic [3:0] wr_be_n,
    output logic wr_data_take,
    output logic [31:0] rd_data,
    output logic rd_valid,
    input wire logic bus_hold_req_n,
    input wire logic grant_suppress,
    output logic bus_grant_ack_n,
    output logic [3:0] chip_sel_n,
    output logic [3:0] chip_sel_oe_n,
    output logic [3:0] byte_lane_select_n,
    output logic [3:0] byte_lane_select_oe_n,
    output logic [31:0] mem_data_bus_o,
    output logic [31:0] mem_data_bus_oe_n,
    input wire logic [31:0] mem_data_bus_i,
    output logic [19:0] mem_word_addr,
    output logic [19:0] mem_word_addr_oe_n,
    output emsb_strobe_t strobe,
    output logic [2:0] strobe_oe_n
);
    logic [1:0] ck_sync_q, ck_sync_d;
    logic ck_prev_q, ck_prev_d;
    logic [1:0] hold_sync_q, hold_sync_d;
    logic ck_rise;
    logic hold_n;

    always_comb begin
        ck_sync_d = {ck_sync_q[0], mem_clk_in};
        ck_prev_d = ck_sync_q[1];
        hold_sync_d = {hold_sync_q[0], bus_hold_req_n};
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ck_sync_q <= EMSB_SYNC_RESET;
            ck_prev_q <= 1'b0;
            // Request sync resets to the released level so reset never looks like a takeover
            hold_sync_q <= 2'h3;
        end else begin
            ck_sync_q <= ck_sync_d;
            ck_prev_q <= ck_prev_d;
            hold_sync_q <= hold_sync_d;
        end
    end

    // All pin activity except mem_clk_out advances on the interface clock's rising edge
    assign ck_rise = ck_sync_q[1] & ~ck_prev_q;
    assign hold_n = hold_sync_q[1];

    emsb_state_t st_q, st_d;
    logic [3:0] ecnt_q, ecnt_d;
    logic [1:0] beat_q, beat_d;
    logic ord_dec_q, ord_dec_d;
    logic ord_rnd_q, ord_rnd_d;
    logic wr_q, wr_d;
    logic [19:0] addr_q, addr_d;
    logic [3:0] cs_q, cs_d;
    logic [31:0] dout_q, dout_d;
    logic [3:0] be_q, be_d;
    emsb_strobe_t stb_q, stb_d;
    logic float_q, float_d;
    logic ack_n_q, ack_n_d;
    logic mclk_q, mclk_d;
    logic [31:0] rdat_q, rdat_d;
    logic rval_q, rval_d;
    logic take;
    logic cmd_beat;

    assign take = ck_rise && req_valid && hold_n
        && (st_q == EMSB_S_IDLE || (st_q == EMSB_S_BURST && beat_q == EMSB_BURST_LAST));
    assign req_ready = take;
    assign wr_data_take = ck_rise && wr_q && (st_q == EMSB_S_BURST);
    // Non-incrementing orders put a fresh column command on every beat
    assign cmd_beat = ord_dec_q | ord_rnd_q;

    always_comb begin
        st_d = st_q;
        ecnt_d = ecnt_q;
        beat_d = beat_q;
        ord_dec_d = ord_dec_q;
        ord_rnd_d = ord_rnd_q;
        wr_d = wr_q;
        addr_d = addr_q;
        cs_d = cs_q;
        dout_d = dout_q;
        be_d = be_q;
        stb_d = stb_q;
        float_d = float_q;
        ack_n_d = ack_n_q;
        mclk_d = ck_sync_q[1];
        rdat_d = rdat_q;
        rval_d = 1'b0;
        if (ck_rise) begin
            stb_d = '{col_strobe_n: 1'b1, sdram_write_strobe_n: 1'b1, row_strobe_n: 1'b1};
            case (st_q)
                EMSB_S_IDLE: begin
                    cs_d = 4'hf;
                    if (take) begin
                        wr_d = req.write;
                        ord_dec_d = (req.order == EMSB_ORD_DEC);
                        ord_rnd_d = (req.order == EMSB_ORD_RND);
                        addr_d = req.addr;
                        cs_d = req.cs_n;
                        stb_d.row_strobe_n = 1'b0;
                        st_d = EMSB_S_ACT;
                    end else if (!hold_n && !grant_suppress) begin
                        ecnt_d = EMSB_CNT_RESET;
                        st_d = EMSB_S_HWAIT;
                    end
                end
                EMSB_S_ACT: begin
                    stb_d.col_strobe_n = 1'b0;
                    stb_d.sdram_write_strobe_n = ~wr_q;
                    beat_d = 2'h0;
                    st_d = EMSB_S_BURST;
                end
                EMSB_S_BURST: begin
                    if (wr_q) begin
                        dout_d = wr_data;
                        be_d = wr_be_n;
                    end else begin
                        rdat_d = mem_data_bus_i;
                        rval_d = 1'b1;
                    end
                    beat_d = beat_q + 2'h1;
                    if (beat_q != EMSB_BURST_LAST) begin
                        if (cmd_beat) begin
                            // Interrupting command carries the next column itself
                            addr_d = ord_dec_q ? addr_q - 20'h1 : addr_q ^ 20'h1;
                            stb_d.col_strobe_n = 1'b0;
                            stb_d.sdram_write_strobe_n = ~wr_q;
                        end
                    end else if (take) begin
                        // Next burst chained with no idle beat
                        wr_d = req.write;
                        ord_dec_d = (req.order == EMSB_ORD_DEC);
                        ord_rnd_d = (req.order == EMSB_ORD_RND);
                        addr_d = req.addr;
                        cs_d = req.cs_n;
                        beat_d = 2'h0;
                        stb_d.col_strobe_n = 1'b0;
                        stb_d.sdram_write_strobe_n = ~req.write;
                    end else begin
                        st_d = EMSB_S_IDLE;
                    end
                end
                EMSB_S_HWAIT: begin
                    ecnt_d = ecnt_q + 4'h1;
                    if (hold_n) begin
                        st_d = EMSB_S_IDLE;
                    end else if (grant_suppress) begin
                        // Suppress raised while waiting still wins over a grant not yet given
                        st_d = EMSB_S_IDLE;
                    end else if (ecnt_q + 4'h1 >= EMSB_HIZ_MIN_E) begin
                        float_d = 1'b1;
                        ecnt_d = EMSB_CNT_RESET;
                        st_d = EMSB_S_HIZ;
                    end
                end
                EMSB_S_HIZ: begin
                    ack_n_d = 1'b0;
                    st_d = EMSB_S_HELD;
                end
                EMSB_S_HELD: begin
                    // Request is sampled again only from here on
                    if (hold_n) begin
                        ecnt_d = EMSB_CNT_RESET;
                        st_d = EMSB_S_DRV;
                    end
                end
                EMSB_S_DRV: begin
                    ecnt_d = ecnt_q + 4'h1;
                    if (ecnt_q + 4'h1 >= EMSB_DRV_MIN_E && float_q) begin
                        float_d = 1'b0;
                    end
                    // Grant is released only once the pins drive again
                    if (!float_q) begin
                        ack_n_d = 1'b1;
                        st_d = EMSB_S_IDLE;
                    end
                end
                default: st_d = EMSB_S_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_q <= EMSB_S_IDLE;
            ecnt_q <= EMSB_CNT_RESET;
            beat_q <= 2'h0;
            ord_dec_q <= 1'b0;
            ord_rnd_q <= 1'b0;
            wr_q <= 1'b0;
            addr_q <= 20'h0;
            cs_q <= 4'hf;
            dout_q <= 32'h0;
            be_q <= 4'hf;
            stb_q <= 3'h7;
            float_q <= 1'b0;
            ack_n_q <= 1'b1;
            mclk_q <= 1'b0;
            rdat_q <= 32'h0;
            rval_q <= 1'b0;
        end else begin
            st_q <= st_d;
            ecnt_q <= ecnt_d;
            beat_q <= beat_d;
            ord_dec_q <= ord_dec_d;
            ord_rnd_q <= ord_rnd_d;
            wr_q <= wr_d;
            addr_q <= addr_d;
            cs_q <= cs_d;
            dout_q <= dout_d;
            be_q <= be_d;
            stb_q <= stb_d;
            float_q <= float_d;
            ack_n_q <= ack_n_d;
            mclk_q <= mclk_d;
            rdat_q <= rdat_d;
            rval_q <= rval_d;
        end
    end

    // Pad enables: one flop per pin, kept in one register per pin group, switching on the same edge as the float state
    logic [3:0] cs_oe_n_q, cs_oe_n_d;
    logic [3:0] be_oe_n_q, be_oe_n_d;
    logic [19:0] addr_oe_n_q, addr_oe_n_d;
    logic [2:0] stb_oe_n_q, stb_oe_n_d;
    logic [31:0] dat_oe_n_q, dat_oe_n_d;

    always_comb begin
        cs_oe_n_d = {4{float_d}};
        be_oe_n_d = {4{float_d}};
        addr_oe_n_d = {20{float_d}};
        stb_oe_n_d = {3{float_d}};
        // Data lanes follow the chip select so an idle bus never fights a reading device
        dat_oe_n_d = {32{float_d | ~wr_d | (cs_d == 4'hf)}};
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cs_oe_n_q <= 4'h0;
            be_oe_n_q <= 4'h0;
            addr_oe_n_q <= 20'h0;
            stb_oe_n_q <= 3'h0;
            dat_oe_n_q <= 32'hffffffff;
        end else begin
            cs_oe_n_q <= cs_oe_n_d;
            be_oe_n_q <= be_oe_n_d;
            addr_oe_n_q <= addr_oe_n_d;
            stb_oe_n_q <= stb_oe_n_d;
            dat_oe_n_q <= dat_oe_n_d;
        end
    end

    // Data lanes drive only while a write burst owns the bus
    always_comb begin
        mem_clk_out = mclk_q;
        bus_grant_ack_n = ack_n_q;
        chip_sel_n = cs_q;
        byte_lane_select_n = be_q;
        mem_data_bus_o = dout_q;
        mem_word_addr = addr_q;
        strobe = stb_q;
        rd_data = rdat_q;
        rd_valid = rval_q;
        chip_sel_oe_n = cs_oe_n_q;
        byte_lane_select_oe_n = be_oe_n_q;
        mem_word_addr_oe_n = addr_oe_n_q;
        strobe_oe_n = stb_oe_n_q;
        mem_data_bus_oe_n = dat_oe_n_q;
    end
endmodule : emsb_ctrl

// ===== rtl/emsb_pkg.sv
package emsb_pkg;
    localparam int EMSB_BURST_LEN = 4;
    localparam logic [1:0] EMSB_BURST_LAST = 2'h3;
    localparam logic [3:0] EMSB_HIZ_MIN_E = 4'h2;
    localparam logic [3:0] EMSB_ACK_MAX_E = 4'h2;
    localparam logic [3:0] EMSB_DRV_MIN_E = 4'h2;
    localparam logic [3:0] EMSB_DRV_MAX_E = 4'h7;
    localparam logic [3:0] EMSB_CNT_RESET = 4'h0;
    localparam logic [1:0] EMSB_SYNC_RESET = 2'h0;

    typedef enum logic [1:0] {
        EMSB_ORD_INC = 2'b00,
        EMSB_ORD_DEC = 2'b01,
        EMSB_ORD_RND = 2'b10
    } emsb_order_t;

    typedef enum logic [2:0] {
        EMSB_S_IDLE = 3'b000,
        EMSB_S_ACT = 3'b001,
        EMSB_S_BURST = 3'b010,
        EMSB_S_HWAIT = 3'b011,
        EMSB_S_HIZ = 3'b100,
        EMSB_S_HELD = 3'b101,
        EMSB_S_DRV = 3'b110
    } emsb_state_t;

    // Strobe pins in their SDRAM roles, all active low
    typedef struct packed {
        logic col_strobe_n;
        logic sdram_write_strobe_n;
        logic row_strobe_n;
    } emsb_strobe_t;

    typedef struct packed {
        logic write;
        emsb_order_t order;
        logic [19:0] addr;
        logic [3:0] cs_n;
    } emsb_req_t;
endpackage : emsb_pkg
